// [rtl/sso_pkg.sv]
package sso_pkg;
  localparam logic [4:0]  REG_CTRL        = 5'h00;
  localparam logic [4:0]  REG_INPOS_RANGE = 5'h04;
  localparam logic [4:0]  REG_PRESET_SPD  = 5'h08;
  localparam logic [4:0]  REG_ZERO_SPD    = 5'h0C;
  localparam logic [4:0]  REG_EVT_STATUS  = 5'h10;
  localparam logic [4:0]  REG_EVT_CLEAR   = 5'h14;
  localparam logic [4:0]  REG_EVT_ENABLE  = 5'h18;
  localparam logic [4:0]  REG_OUT_STATE   = 5'h1C;
  // control fields
  localparam int          CTRL_SPEED_MODE = 0;
  localparam int          CTRL_BRAKE_SEL  = 1;
  localparam int          CTRL_CODE_EN    = 2;
  localparam int          CTRL_WNG_LO     = 4;
  localparam logic [1:0]  WNG_PIN_NONE    = 2'h0;
  localparam logic [1:0]  WNG_PIN_READY   = 2'h1;
  localparam logic [1:0]  WNG_PIN_SETTLED = 2'h2;
  localparam logic [1:0]  WNG_PIN_ZERO    = 2'h3;
  // event bits
  localparam int          EVT_FAULT       = 0;
  localparam int          EVT_WARNING     = 1;
  localparam int          EVT_SETTLED     = 2;
  localparam int          EVT_REACHED     = 3;
  localparam int          EVT_W           = 4;
  // reset values and speed figures, r/min
  localparam logic [15:0] INPOS_RST       = 16'h0064;
  localparam logic [15:0] PRESET_RST      = 16'h0000;
  localparam logic [15:0] ZERO_SPD_RST    = 16'h0032;
  localparam logic [15:0] SA_ALWAYS_MAX   = 16'h0014;
  localparam logic [15:0] SA_TOLERANCE    = 16'h000A;
  // power-on delay
  localparam longint      POWERON_NS      = 64'd1000000000;
  localparam longint      CLK_PERIOD_NS   = 64'd5;
  localparam int          POWERON_CYCLES  = int'(POWERON_NS / CLK_PERIOD_NS);
  // alarm kinds and codes
  localparam logic [3:0]  ALM_WATCHDOG    = 4'h0;
  localparam logic [3:0]  ALM_MEMORY      = 4'h1;
  localparam logic [3:0]  ALM_CLOCK       = 4'h2;
  localparam logic [3:0]  ALM_BOARD       = 4'h3;
  localparam logic [3:0]  ALM_PARAMETER   = 4'h4;
  localparam logic [3:0]  ALM_REGEN       = 4'h5;
  localparam logic [3:0]  ALM_UNDERVOLT   = 4'h6;
  localparam logic [3:0]  ALM_OVERLOAD    = 4'h7;
  localparam logic [3:0]  ALM_OVERCURRENT = 4'h8;
  localparam logic [3:0]  ALM_ENCODER     = 4'h9;
  localparam logic [3:0]  ALM_EXCESS_ERR  = 4'hA;
  localparam logic [2:0]  CODE_NONE       = 3'h0;
  localparam logic [2:0]  CODE_UNDERVOLT  = 3'h1;
  localparam logic [2:0]  CODE_REGEN      = 3'h2;
  localparam logic [2:0]  CODE_OVERLOAD   = 3'h3;
  localparam logic [2:0]  CODE_OVERCUR    = 3'h4;
  localparam logic [2:0]  CODE_ENCODER    = 3'h5;
  localparam logic [2:0]  CODE_EXCESS     = 3'h6;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// [rtl/sso_regbus_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sso_regbus_if;
  logic        wr_en;
  logic [4:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic [4:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;
  modport slave_end (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_err, rd_data, rd_err);
  modport reg_end   (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// [rtl/sso_axil_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module sso_axil_slave
  import sso_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [4:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  input  wire logic [4:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  sso_regbus_if.slave_end   bus
);
  logic        aw_have_r;
  logic        w_have_r;
  logic [4:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        do_wr;

  // a held address or data word blocks its channel until the response is taken
  assign awready = !aw_have_r && !bvalid;
  assign wready  = !w_have_r && !bvalid;
  assign arready = !rvalid;
  assign do_wr   = aw_have_r && w_have_r && !bvalid;

  assign bus.wr_en   = do_wr;
  assign bus.wr_addr = aw_addr_r;
  assign bus.wr_data = w_data_r;
  assign bus.wr_strb = w_strb_r;
  assign bus.rd_addr = araddr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 5'h00;
    end else if (awvalid && awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= awaddr;
    end else if (do_wr) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (wvalid && wready) begin
      w_have_r <= 1'b1;
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end else if (do_wr) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp  <= bus.wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= bus.rd_data;
      rresp  <= bus.rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [rtl/sso_status.sv]
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sso_status
  import sso_pkg::*;
#(
  parameter int DROOP_W     = 24,
  parameter int POWERON_CYC = POWERON_CYCLES
) (
  input  wire logic               SYS_CLK,
  input  wire logic               RST_N,
  input  wire logic [7:0]         S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic [1:0]              S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [7:0]         S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic [31:0]             S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY,
  input  wire logic               SERVO_ON_IN,
  input  wire logic               FORWARD_START_IN,
  input  wire logic               REVERSE_START_IN,
  input  wire logic               AMP_READY,
  input  wire logic               BASE_SHUTOFF,
  input  wire logic               ALARM_ACTIVE,
  input  wire logic [3:0]         ALARM_KIND,
  input  wire logic               WARNING_ACTIVE,
  input  wire logic [DROOP_W-1:0] DROOP_COUNT,
  input  wire logic [15:0]        MOTOR_SPEED,
  output logic                    FAULT_OUT,
  output logic                    READY_OUT,
  output logic                    POSITION_SETTLED_OUT,
  output logic                    ZERO_SPEED_OUT,
  output logic                    SPEED_REACHED_OUT,
  output logic                    IRQ
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] abs16(input logic [15:0] v);
    abs16 = v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [2:0] code_of(input logic [3:0] kind);
    case (kind)
      ALM_REGEN:       code_of = CODE_REGEN;
      ALM_UNDERVOLT:   code_of = CODE_UNDERVOLT;
      ALM_OVERLOAD:    code_of = CODE_OVERLOAD;
      ALM_OVERCURRENT: code_of = CODE_OVERCUR;
      ALM_ENCODER:     code_of = CODE_ENCODER;
      ALM_EXCESS_ERR:  code_of = CODE_EXCESS;
      default:         code_of = CODE_NONE;
    endcase
  endfunction

  // untouched byte lanes keep their value
  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    lane16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ****************************************************************
  // bus slave
  // ****************************************************************
  sso_regbus_if bus ();

  sso_axil_slave u_slave (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .awaddr  (S_AXI_AWADDR[4:0]),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR[4:0]),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .bus     (bus.slave_end)
  );

  // upper address bits beyond the map and misaligned words are unmapped
  logic wr_hi_r;
  logic rd_hi;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_hi_r <= 1'b0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      wr_hi_r <= |S_AXI_AWADDR[7:5];
    end
  end

  assign rd_hi = |S_AXI_ARADDR[7:5];

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [5:0]       ctrl_r;
  logic [15:0]      inpos_r;
  logic [15:0]      preset_r;
  logic [15:0]      zero_r;
  logic [EVT_W-1:0] evt_r;
  logic [EVT_W-1:0] evt_nxt;
  logic [EVT_W-1:0] ien_r;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic             wr_ok;

  assign wr_ok = bus.wr_en && !wr_hi_r && (bus.wr_addr[1:0] == 2'h0);

  // one block per register
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= 6'h00;
    end else if (wr_ok && bus.wr_addr == REG_CTRL && bus.wr_strb[0]) begin
      ctrl_r <= bus.wr_data[5:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      inpos_r <= INPOS_RST;
    end else if (wr_ok && bus.wr_addr == REG_INPOS_RANGE) begin
      inpos_r <= lane16(inpos_r, bus.wr_data, bus.wr_strb);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      preset_r <= PRESET_RST;
    end else if (wr_ok && bus.wr_addr == REG_PRESET_SPD) begin
      preset_r <= lane16(preset_r, bus.wr_data, bus.wr_strb);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      zero_r <= ZERO_SPD_RST;
    end else if (wr_ok && bus.wr_addr == REG_ZERO_SPD) begin
      zero_r <= lane16(zero_r, bus.wr_data, bus.wr_strb);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ien_r <= '0;
    end else if (wr_ok && bus.wr_addr == REG_EVT_ENABLE && bus.wr_strb[0]) begin
      ien_r <= bus.wr_data[EVT_W-1:0];
    end
  end

  always_comb begin
    bus.wr_err = !(wr_ok && (bus.wr_addr == REG_CTRL || bus.wr_addr == REG_INPOS_RANGE ||
                 bus.wr_addr == REG_PRESET_SPD || bus.wr_addr == REG_ZERO_SPD ||
                 bus.wr_addr == REG_EVT_CLEAR ||
                 bus.wr_addr == REG_EVT_ENABLE));
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] pin_m_r;
  logic [2:0] pin_s_r;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_m_r <= 3'h0;
      pin_s_r <= 3'h0;
    end else begin
      pin_m_r <= {REVERSE_START_IN, FORWARD_START_IN, SERVO_ON_IN};
      pin_s_r <= pin_m_r;
    end
  end

  logic servo_on;
  logic any_start;

  assign servo_on  = pin_s_r[0];
  assign any_start = pin_s_r[1] || pin_s_r[2];

  // ****************************************************************
  // power-on delay
  // ****************************************************************
  // counter stops at the end so it cannot wrap back into the delay
  logic [31:0] por_cnt_r;
  logic        por_done_r;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      por_cnt_r  <= 32'h0000_0000;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r  <= por_cnt_r + 32'h0000_0001;
      por_done_r <= (por_cnt_r >= 32'(POWERON_CYC - 1));
    end
  end

  // ****************************************************************
  // status decisions
  // ****************************************************************
  logic [DROOP_W-1:0] droop_abs;
  logic [15:0]        spd_abs;
  logic [15:0]        spd_diff;
  logic               fault_ok;
  logic               ready_ok;
  logic               settled;
  logic               reached;
  logic               zero_spd;
  logic               brake_ok;
  logic               code_on;
  logic [2:0]         code;
  logic [1:0]         wng_pin;

  assign droop_abs = DROOP_COUNT[DROOP_W-1] ? DROOP_W'(-DROOP_COUNT) : DROOP_COUNT;
  assign spd_abs   = abs16(MOTOR_SPEED);
  assign spd_diff  = (spd_abs > preset_r) ? 16'(spd_abs - preset_r) : 16'(preset_r - spd_abs);
  assign fault_ok  = por_done_r && !ALARM_ACTIVE && !BASE_SHUTOFF;
  assign ready_ok  = servo_on && AMP_READY && !BASE_SHUTOFF;
  assign settled   = !ctrl_r[CTRL_SPEED_MODE] && (droop_abs <= DROOP_W'(inpos_r));
  // the start inputs decide nothing; the flag sets near speed or at a preset up to SA_ALWAYS_MAX
  assign reached   = ctrl_r[CTRL_SPEED_MODE] && servo_on &&
                     ((preset_r <= SA_ALWAYS_MAX) ||
                      (spd_diff <= SA_TOLERANCE));
  assign zero_spd  = spd_abs <= zero_r;
  assign brake_ok  = servo_on && !ALARM_ACTIVE;
  assign code_on   = ctrl_r[CTRL_CODE_EN] && ALARM_ACTIVE;
  assign code      = code_of(ALARM_KIND);
  assign wng_pin   = ctrl_r[CTRL_WNG_LO +: 2];

  logic warn_on;
  assign warn_on = por_done_r && WARNING_ACTIVE;

  // ****************************************************************
  // pin drivers, closed contact is one
  // ****************************************************************
  logic ready_nxt;
  logic settled_nxt;
  logic zero_nxt;
  logic reached_nxt;

  always_comb begin
    ready_nxt   = ready_ok;
    settled_nxt = settled;
    zero_nxt    = ctrl_r[CTRL_BRAKE_SEL] ? brake_ok : zero_spd;
    reached_nxt = reached;
    case (wng_pin)
      WNG_PIN_READY:   ready_nxt   = warn_on;
      WNG_PIN_SETTLED: settled_nxt = warn_on;
      WNG_PIN_ZERO:    zero_nxt    = warn_on;
      default:         ;
    endcase
    if (code_on) begin
      zero_nxt    = code[2];
      ready_nxt   = code[1];
      settled_nxt = code[0];
      reached_nxt = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FAULT_OUT            <= 1'b0;
      READY_OUT            <= 1'b0;
      POSITION_SETTLED_OUT <= 1'b0;
      ZERO_SPEED_OUT       <= 1'b0;
      SPEED_REACHED_OUT    <= 1'b0;
    end else begin
      FAULT_OUT            <= fault_ok;
      READY_OUT            <= ready_nxt;
      POSITION_SETTLED_OUT <= settled_nxt;
      ZERO_SPEED_OUT       <= zero_nxt;
      SPEED_REACHED_OUT    <= reached_nxt;
    end
  end

  // ****************************************************************
  // events and interrupt
  // ****************************************************************
  // edges are taken on the internal decisions, so pin remapping does not hide them
  logic [EVT_W-1:0] lvl_r;
  logic [EVT_W-1:0] lvl;

  assign lvl     = {reached, settled, warn_on, !fault_ok};
  assign evt_set = lvl & ~lvl_r;
  assign evt_clr = (wr_ok && bus.wr_addr == REG_EVT_CLEAR && bus.wr_strb[0]) ?
                   bus.wr_data[EVT_W-1:0] : '0;
  assign evt_nxt = (evt_r & ~evt_clr) | evt_set;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // fault is open at reset: no false edge
      lvl_r <= EVT_W'(1) << EVT_FAULT;
      evt_r <= '0;
      IRQ   <= 1'b0;
    end else begin
      lvl_r <= lvl;
      evt_r <= evt_nxt;
      IRQ   <= |(evt_nxt & ien_r);
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  // reads have no side effects
  always_comb begin
    bus.rd_data = 32'h0000_0000;
    bus.rd_err  = 1'b0;
    case (bus.rd_addr)
      REG_CTRL:        bus.rd_data[5:0]       = ctrl_r;
      REG_INPOS_RANGE: bus.rd_data[15:0]      = inpos_r;
      REG_PRESET_SPD:  bus.rd_data[15:0]      = preset_r;
      REG_ZERO_SPD:    bus.rd_data[15:0]      = zero_r;
      REG_EVT_STATUS:  bus.rd_data[EVT_W-1:0] = evt_r;
      REG_EVT_CLEAR:   bus.rd_data            = 32'h0000_0000;
      REG_EVT_ENABLE:  bus.rd_data[EVT_W-1:0] = ien_r;
      REG_OUT_STATE:   bus.rd_data[5:0]       = {IRQ, SPEED_REACHED_OUT, ZERO_SPEED_OUT,
                                                 POSITION_SETTLED_OUT, READY_OUT, FAULT_OUT};
      default:         bus.rd_err             = 1'b1;
    endcase
    if (rd_hi) begin
      bus.rd_data = 32'h0000_0000;
      bus.rd_err  = 1'b1;
    end
  end
endmodule
`default_nettype wire

// [dv/sso_status_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// status output checker
// ****************************************
module sso_status_monitor
  import sso_pkg::*;
#(
  parameter int POWERON_CYC = POWERON_CYCLES
) (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        SERVO_ON_IN,
  input wire logic        AMP_READY,
  input wire logic        BASE_SHUTOFF,
  input wire logic        ALARM_ACTIVE,
  input wire logic        WARNING_ACTIVE,
  input wire logic        FAULT_OUT,
  input wire logic        READY_OUT,
  input wire logic        SPEED_REACHED_OUT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // saturates so a long run never wraps back into the power-on window
  int up_cnt_r;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) up_cnt_r <= 0;
    else if (up_cnt_r < POWERON_CYC + 8) up_cnt_r <= up_cnt_r + 1;
  end
  chk_fault_shutoff: assert property (BASE_SHUTOFF |=> !FAULT_OUT)
    else $error("fault contact closed during shutoff");
  chk_fault_alarm: assert property (ALARM_ACTIVE |=> !FAULT_OUT)
    else $error("fault contact closed during alarm");
  chk_fault_early: assert property ((up_cnt_r < POWERON_CYC) |-> !FAULT_OUT)
    else $error("fault contact closed before power-on delay");
  chk_fault_closes: assert property ((up_cnt_r >= POWERON_CYC + 4 && !ALARM_ACTIVE && !BASE_SHUTOFF) |=> FAULT_OUT)
    else $error("fault contact still open after power-on delay");
  chk_ready_gate: assert property ((!AMP_READY && !ALARM_ACTIVE && !WARNING_ACTIVE) |=> !READY_OUT)
    else $error("ready closed while amplifier not ready");
  chk_reached_servo: assert property (!SERVO_ON_IN [*4] |=> !SPEED_REACHED_OUT)
    else $error("speed reached while servo off");
  chk_read_answer: assert property ((S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID)
    else $error("read data late");
  chk_read_clear: assert property ((S_AXI_RVALID && S_AXI_RREADY) |=> !S_AXI_RVALID)
    else $error("read data not released");
endmodule
bind sso_status sso_status_monitor #(.POWERON_CYC(POWERON_CYC)) u_mon (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .SERVO_ON_IN(SERVO_ON_IN),
  .AMP_READY(AMP_READY), .BASE_SHUTOFF(BASE_SHUTOFF), .ALARM_ACTIVE(ALARM_ACTIVE),
  .WARNING_ACTIVE(WARNING_ACTIVE), .FAULT_OUT(FAULT_OUT), .READY_OUT(READY_OUT),
  .SPEED_REACHED_OUT(SPEED_REACHED_OUT));
`default_nettype wire

// [dv/sso_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host controller input stage
// ****************************************
module sso_host_model (
  input  wire logic  clk,
  input  wire logic  fault_in,
  input  wire logic  ready_in,
  input  wire logic  settled_in,
  input  wire logic  zero_in,
  input  wire logic  reached_in,
  output logic [4:0] view
);
  // one sample per clock, no debounce: a glitching contact shows up as is
  always_ff @(posedge clk) view <= {reached_in, zero_in, settled_in, ready_in, fault_in};
endmodule
`default_nettype wire

// [dv/sso_status_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// status output bench
// ****************************************
module sso_status_test;
  import sso_pkg::*;
  localparam int PWR = 20;
  logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic        servo_on_in = 0, fwd = 0, rev = 0, amp = 0, base = 0, fault_out = 0, warning_out = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  kind = 0, strb = 4'hF;
  logic [23:0] droop = 0;
  logic [15:0] spd = 0;
  logic        awr, wrdy, bv, arr, rv, fault, rdy, setl, zero, sa, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [4:0]  hv;
  logic [2:0]  codes [0:10] = '{CODE_NONE, CODE_NONE, CODE_NONE, CODE_NONE, CODE_NONE, CODE_REGEN,
                                CODE_UNDERVOLT, CODE_OVERLOAD, CODE_OVERCUR, CODE_ENCODER, CODE_EXCESS};
  int          failures = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  sso_status #(.DROOP_W(24), .POWERON_CYC(PWR)) dut (
    .SYS_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready), .SERVO_ON_IN(servo_on_in), .FORWARD_START_IN(fwd), .REVERSE_START_IN(rev),
    .AMP_READY(amp), .BASE_SHUTOFF(base), .ALARM_ACTIVE(fault_out), .ALARM_KIND(kind), .WARNING_ACTIVE(warning_out),
    .DROOP_COUNT(droop), .MOTOR_SPEED(spd), .FAULT_OUT(fault), .READY_OUT(rdy),
    .POSITION_SETTLED_OUT(setl), .ZERO_SPEED_OUT(zero), .SPEED_REACHED_OUT(sa), .IRQ(irq));
  sso_host_model host (.clk(clk), .fault_in(fault), .ready_in(rdy), .settled_in(setl), .zero_in(zero),
    .reached_in(sa), .view(hv));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a wait that runs out counts against the run and ends it
  task automatic hang(input string nm);
    chk(nm, 1'b0, 1'b1);
    end_of_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awv, wv, bready} <= 3'h7;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrdy) wv <= 0;
      if (bv) break;
    end
    if (n == 40) hang("write response");
    bready <= 0;
    chk("bresp", bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    {arv, rready} <= 2'h3;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv) break;
    end
    if (n == 40) hang("read data");
    rready <= 0;
    chk("rresp", rresp, er);
    chk("rdata", rdata & m, exp);
  endtask
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask
  task automatic s_regs;
    rd(8'h04, {16'h0, INPOS_RST}, 32'hFFFF, RESP_OKAY);
    rd(8'h0C, {16'h0, ZERO_SPD_RST}, 32'hFFFF, RESP_OKAY);
    rd(8'h20, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h10, 32'hF, RESP_SLVERR);
  endtask
  task automatic s_fault;
    base <= 1;
    settle();
    chk("fault shutoff", hv[0], 1'b0);
    base <= 0;
    fault_out <= 1;
    settle();
    chk("fault alarm", hv[0], 1'b0);
    fault_out <= 0;
    settle();
    chk("fault clear", hv[0], 1'b1);
  endtask
  task automatic s_ready;
    {servo_on_in, amp} <= 2'h3;
    settle();
    chk("ready on", hv[1], 1'b1);
    amp <= 0;
    settle();
    chk("ready amp", hv[1], 1'b0);
    {amp, base} <= 2'h3;
    settle();
    chk("ready shutoff", hv[1], 1'b0);
    base <= 0;
  endtask
  task automatic s_settled;
    droop <= 24'h64;
    settle();
    chk("settled edge", hv[2], 1'b1);
    droop <= 24'h65;
    settle();
    chk("settled out", hv[2], 1'b0);
    droop <= 24'hFFFF9C;
    settle();
    chk("settled neg", hv[2], 1'b1);
    wr(8'h04, 32'h10, RESP_OKAY);
    settle();
    chk("settled range", hv[2], 1'b0);
  endtask
  task automatic s_speed;
    wr(8'h00, 32'h1, RESP_OKAY);
    wr(8'h08, 32'h3E8, RESP_OKAY);
    fwd <= 1;
    spd <= 16'h3E3;
    settle();
    chk("reached near", hv[4], 1'b1);
    {fwd, spd} <= {1'b0, 16'h1F4};
    settle();
    chk("reached far", hv[4], 1'b0);
    {servo_on_in, rev, spd} <= {2'h1, 16'h3E8};
    settle();
    chk("reached servo off", hv[4], 1'b0);
    {servo_on_in, rev, spd} <= {2'h2, 16'h0};
    wr(8'h08, 32'h14, RESP_OKAY);
    settle();
    chk("reached low preset", hv[4], 1'b1);
    wr(8'h08, 32'h15, RESP_OKAY);
    settle();
    chk("reached above low", hv[4], 1'b0);
  endtask
  task automatic s_zero;
    wr(8'h00, 32'h0, RESP_OKAY);
    spd <= 16'h32;
    settle();
    chk("zero at limit", hv[3], 1'b1);
    spd <= 16'h33;
    settle();
    chk("zero above", hv[3], 1'b0);
    wr(8'h0C, 32'h64, RESP_OKAY);
    spd <= 16'h50;
    settle();
    chk("zero new limit", hv[3], 1'b1);
  endtask
  task automatic s_brake;
    wr(8'h00, 32'h2, RESP_OKAY);
    spd <= 16'h3E8;
    settle();
    chk("brake closed", hv[3], 1'b1);
    fault_out <= 1;
    settle();
    chk("brake alarm", hv[3], 1'b0);
    {fault_out, servo_on_in} <= 2'h0;
    settle();
    chk("brake servo off", hv[3], 1'b0);
  endtask
  task automatic s_warn;
    droop <= 24'h7FFFFF;
    for (int i = 1; i < 4; i++) begin
      wr(8'h00, 32'(i) << 4, RESP_OKAY);
      warning_out <= 1;
      settle();
      chk("warning pin", hv[i], 1'b1);
      warning_out <= 0;
      settle();
      chk("warning off", hv[i], 1'b0);
    end
  endtask
  task automatic s_code;
    wr(8'h00, 32'h4, RESP_OKAY);
    for (int k = 0; k < 11; k++) begin
      {fault_out, kind} <= {1'b1, 4'(k)};
      settle();
      chk("alarm code", {hv[3], hv[1], hv[2]}, codes[k]);
      fault_out <= 0;
      settle();
    end
    servo_on_in <= 1;
    settle();
    chk("normal after alarm", hv[1], 1'b1);
  endtask
  task automatic s_irq;
    wr(8'h00, 32'h0, RESP_OKAY);
    wr(8'h18, 32'h0, RESP_OKAY);
    wr(8'h14, 32'hF, RESP_OKAY);
    rd(8'h10, 32'h0, 32'h2, RESP_OKAY);
    warning_out <= 1;
    settle();
    rd(8'h10, 32'h2, 32'h2, RESP_OKAY);
    chk("irq masked", irq, 1'b0);
    wr(8'h18, 32'h2, RESP_OKAY);
    settle();
    chk("irq raised", irq, 1'b1);
    warning_out <= 0;
    wr(8'h14, 32'h2, RESP_OKAY);
    settle();
    rd(8'h10, 32'h0, 32'h2, RESP_OKAY);
    chk("irq cleared", irq, 1'b0);
    rd(8'h14, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    chk("fault at power-on", hv[0], 1'b0);
    s_regs();
    repeat (PWR + 8) @(posedge clk);
    chk("fault after delay", hv[0], 1'b1);
    s_fault();
    s_ready();
    s_settled();
    s_speed();
    s_zero();
    s_brake();
    s_warn();
    s_code();
    s_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
